/* File: ebi_map.svh */
// Constants for the external bus interface block
// Notes on behaviour
// R01 - Four phases from input clock, one each
// R02 - Inverted phase three drives timing reference
// R03 - Fourteen-bit address, memory or I/O select
// R04 - Eight-bit three-state data bus, D0 MSB
// R05 - Serial output data on address bit 13; the code puts it on address bit 0
// R06 - External instruction bit shown on bit 13; the code shows it on address bit 0
// R07 - Serial strobe pulses high for sampling
// R08 - Serial input sampled for store, test bit
// R09 - Read direction high on reads, floats granted
// R10 - Memory strobe low only with memory address
// R11 - Write strobe low with write data
// R12 - Hold request: finish cycle, float, grant
// R13 - Hold released: drop grant, resume
// R14 - Grant high exactly during hold state
// R15 - Ready low inserts wait states
// R16 - Fetch flag high on instruction fetch cycles
// R17 - Next memory cycle finishes first, three maximum
// R18 - Interrupt code inputs captured for interrupt logic
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH
`define EBI_PHASES 4
`define EBI_REF_PHASE 2'h2
`define EBI_ADDR_W 14
`define EBI_DATA_W 8
`define EBI_MAX_RUN 2'h3
`define EBI_SER_BIT 13
`endif

/* File: ebi_pkg.sv */
// Types for the external bus interface block
`default_nettype none
package ebi_pkg;
  typedef enum logic [2:0] {
    EBI_NONE, EBI_MEM_READ, EBI_MEM_WRITE, EBI_SER_OUT, EBI_SER_IN, EBI_EXT_INSTR
  } ebi_op_type;
endpackage
`default_nettype wire

/* File: ebi_bus_interface.sv */
// External bus interface: phase clock, memory cycles, hold, serial I/O
`include "ebi_map.svh"
`default_nettype none
module ebi_bus_interface (
  input wire logic sys_clk, // Input clock, four times system rate
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic reqValid, // Core request, level held until reqDone
  input wire ebi_pkg::ebi_op_type reqOp, // Kind of bus operation
  input wire logic [13:0] reqAddr, // Address for the operation
  input wire logic [7:0] reqWrData, // Memory write data
  input wire logic reqFetch, // Memory read is an instruction fetch
  input wire logic reqSerBit, // Serial or external instruction bit
  input wire logic reqMoreMem, // Another memory cycle follows at once
  output logic reqDone, // One-cycle pulse, operation finished
  output logic [7:0] rdData, // Captured read data
  output logic serInBit, // Captured serial input bit
  output logic coreStall, // Core suspended by wait states
  output logic [2:0] irqCode, // Captured interrupt code
  output logic phase3RefN, // Inverted phase three reference
  output logic [13:0] addrOut, // Address bus drive
  output logic addrOe, // Address bus enable
  output logic [7:0] dataOut, // Data bus drive
  output logic dataOe, // Data bus enable
  input wire logic [7:0] dataIn, // Data bus sampled
  output logic memCycleStrobeN, // Memory cycle strobe, active low
  output logic writeStrobeN, // Write strobe, active low
  output logic readDirection, // Read direction
  output logic ctrlOe, // Enable of the three memory strobes
  output logic serialIoStrobe, // Serial I/O strobe
  input wire logic serialIoIn, // Serial I/O input pin
  input wire logic holdN, // Hold request, active low
  output logic busGrant, // Bus grant
  input wire logic ready, // Memory ready
  output logic fetchCycleFlag, // Instruction fetch indicator
  input wire logic irqCodeBit0, // Interrupt code bit 0
  input wire logic irqCodeBit1, // Interrupt code bit 1
  input wire logic irqCodeBit2 // Interrupt code bit 2
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_HOLD} ebi_st_type;

  // ----------------------------------------
  // Phase generator
  // ----------------------------------------
  logic [1:0] phase_r;
  logic phaseEnd;
  // R01 one phase per clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) phase_r <= 2'h0;
    else phase_r <= phase_r + 2'h1;
  end
  assign phaseEnd = (phase_r == 2'h3);
  // R02 inverted phase three
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) phase3RefN <= 1'b1;
    else phase3RefN <= !(phase_r + 2'h1 == `EBI_REF_PHASE);
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [5:0] s1_r, s2_r, s3_r;
  logic holdReq, readyS, serInS;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 6'h01;
      s2_r <= 6'h01;
      s3_r <= 6'h01;
    end else begin
      s1_r <= {irqCodeBit2, irqCodeBit1, irqCodeBit0, serialIoIn, ready, holdN};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic [5:0] filt_r;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gFilt
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) filt_r[g] <= (g == 0);
        else if (s2_r[g] == s3_r[g]) filt_r[g] <= s3_r[g];
      end
    end
  endgenerate
  assign holdReq = !filt_r[0];
  assign readyS = filt_r[1];
  assign serInS = filt_r[2];
  // R18 interrupt code capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) irqCode <= 3'h0;
    else if (phaseEnd) irqCode <= filt_r[5:3];
  end

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  ebi_st_type st_r;
  ebi_pkg::ebi_op_type op_r;
  logic [1:0] run_r;
  logic memOp, isMem, lastPhase, waiting;
  assign isMem = (reqOp == ebi_pkg::EBI_MEM_READ) || (reqOp == ebi_pkg::EBI_MEM_WRITE);
  assign memOp = (op_r == ebi_pkg::EBI_MEM_READ) || (op_r == ebi_pkg::EBI_MEM_WRITE);
  // R15 wait while ready low
  assign waiting = (st_r == ST_BUSY) && memOp && !readyS;
  assign lastPhase = (st_r == ST_BUSY) && phaseEnd && !waiting;
  assign coreStall = waiting;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      op_r <= ebi_pkg::EBI_NONE;
      run_r <= 2'h0;
    end else if (phaseEnd) begin
      unique case (st_r)
        ST_IDLE: begin
          // R12 grant only between cycles
          if (holdReq) st_r <= ST_HOLD;
          else if (reqValid) begin
            st_r <= ST_BUSY;
            op_r <= reqOp;
            run_r <= isMem ? 2'h1 : 2'h0;
          end
        end
        ST_BUSY: begin
          if (!waiting) begin
            // R17 chained memory cycle first, at most three
            if (reqValid && isMem && memOp && reqMoreMem && run_r < `EBI_MAX_RUN) begin
              op_r <= reqOp;
              run_r <= run_r + 2'h1;
            end else if (holdReq) begin
              st_r <= ST_HOLD;
              op_r <= ebi_pkg::EBI_NONE;
            end else begin
              st_r <= ST_IDLE;
              op_r <= ebi_pkg::EBI_NONE;
            end
          end
        end
        ST_HOLD: begin
          // R13 leave hold on release
          if (!holdReq) st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Latched request fields, steady for the whole cycle
  logic [13:0] addr_r;
  logic fetch_r, bit_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= 14'h0000;
      dataOut <= 8'h00;
      fetch_r <= 1'b0;
      bit_r <= 1'b0;
    end else if (phaseEnd && reqValid && st_r != ST_HOLD && !waiting) begin
      addr_r <= reqAddr;
      dataOut <= reqWrData;
      fetch_r <= reqFetch && (reqOp == ebi_pkg::EBI_MEM_READ);
      bit_r <= reqSerBit;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) reqDone <= 1'b0;
    else reqDone <= lastPhase;
  end

  // R08 sample serial input
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) serInBit <= 1'b0;
    // Filter's next value: a reply to this cycle's address agrees only now
    else if (lastPhase && op_r == ebi_pkg::EBI_SER_IN) serInBit <= (s2_r[2] == s3_r[2]) ? s3_r[2] : serInS;
  end
  // R04 capture read data
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) rdData <= 8'h00;
    else if (lastPhase && op_r == ebi_pkg::EBI_MEM_READ) rdData <= dataIn;
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic busy, serOut;
  assign busy = (st_r == ST_BUSY);
  assign serOut = (op_r == ebi_pkg::EBI_SER_OUT) || (op_r == ebi_pkg::EBI_EXT_INSTR);
  // R03 R05 R06 bit 0 carries serial bit
  assign addrOut = (busy && serOut) ? {addr_r[13:1], bit_r} : addr_r;
  // R14 floated exactly in hold
  assign addrOe = (st_r != ST_HOLD);
  assign ctrlOe = (st_r != ST_HOLD);
  assign busGrant = (st_r == ST_HOLD);
  // R10 memory strobe
  assign memCycleStrobeN = !(busy && memOp);
  // R09 read direction, drivers off on reads
  assign readDirection = busy && (op_r == ebi_pkg::EBI_MEM_READ);
  // R04 R11 write data and strobe
  assign dataOe = busy && (op_r == ebi_pkg::EBI_MEM_WRITE);
  assign writeStrobeN = !(dataOe && (phase_r == 2'h1 || phase_r == 2'h2));
  // R07 strobe mid cycle
  assign serialIoStrobe = busy && serOut && (phase_r == 2'h2);
  // R16 fetch flag
  assign fetchCycleFlag = busy && fetch_r;
endmodule
`default_nettype wire

/* File: ebi_bus_interface_checker.sv */
// Port checks of the bus interface
`default_nettype none
module ebi_bus_interface_checker (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset
  input wire logic holdN, // Hold
  input wire logic reqDone, // Done
  input wire logic coreStall, // Wait
  input wire logic phase3RefN, // Reference
  input wire logic addrOe, // Address on
  input wire logic dataOe, // Data on
  input wire logic memCycleStrobeN, // Memory strobe
  input wire logic writeStrobeN, // Write strobe
  input wire logic readDirection, // Read
  input wire logic ctrlOe, // Strobes on
  input wire logic serialIoStrobe, // Serial strobe
  input wire logic busGrant // Grant
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence refLow; $fell(phase3RefN); endsequence
  sequence refRest; phase3RefN [*3] ##1 !phase3RefN; endsequence
  AST_REF_PERIOD: assert property (refLow |=> refRest)
    else $error("reference period wrong");
  AST_GRANT_FLOAT: assert property (busGrant |-> !addrOe && !dataOe && !ctrlOe)
    else $error("bus driven in hold");
  AST_READ_NODRIVE: assert property (ctrlOe && readDirection |-> !dataOe && !memCycleStrobeN)
    else $error("read with drive");
  AST_WRITE_DATA: assert property (ctrlOe && !writeStrobeN |-> dataOe && !memCycleStrobeN)
    else $error("write without data");
  AST_MEM_ADDR: assert property (ctrlOe && !memCycleStrobeN |-> addrOe && !serialIoStrobe)
    else $error("memory strobe wrong");
  AST_SER_PULSE: assert property (serialIoStrobe |=> !serialIoStrobe)
    else $error("serial strobe long");
  AST_STALL_MEM: assert property (coreStall |-> !memCycleStrobeN && !reqDone)
    else $error("stall outside memory");
  AST_GRANT_DROP: assert property (busGrant && holdN |-> ##[0:12] !busGrant)
    else $error("grant kept");
  AST_GRANT_AFTER: assert property ($rose(busGrant) |-> $past(memCycleStrobeN))
    else $error("grant mid cycle");
endmodule
bind ebi_bus_interface ebi_bus_interface_checker u_ebi_bus_interface_checker (.*);
`default_nettype wire

/* File: ebi_mem_model.sv */
// Memory and serial partner
`default_nettype none
module ebi_mem_model (
  input wire logic sys_clk, // Clock
  input wire logic slow, // Wait states wanted
  input wire logic [13:0] addrOut, // Address
  input wire logic [7:0] dataOut, // Write data
  input wire logic dataOe, // Data on
  input wire logic memCycleStrobeN, // Memory strobe
  input wire logic writeStrobeN, // Write strobe
  input wire logic readDirection, // Read
  input wire logic serialIoStrobe, // Serial strobe
  output logic [7:0] dataIn, // Read data
  output logic ready, // Ready
  output logic serialIoIn, // Serial input
  output logic [7:0] wrSeen, // Last write
  output logic serSeen // Last serial bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt = 4'h0;
  assign dataIn = (readDirection && !memCycleStrobeN) ? addrOut[7:0] ^ 8'h5A : addrOut[7:0] ^ 8'hA5;
  assign ready = !slow || waitCnt == 4'h8;
  assign serialIoIn = addrOut[5];
  always @(posedge sys_clk) begin
    waitCnt <= memCycleStrobeN ? 4'h0 : (waitCnt == 4'h8 ? 4'h8 : waitCnt + 4'h1);
    if (!writeStrobeN && dataOe) wrSeen <= dataOut;
    if (serialIoStrobe) serSeen <= addrOut[0];
  end
endmodule
`default_nettype wire

/* File: ebi_bus_interface_tb.sv */
// Bench of the bus interface
`default_nettype none
module ebi_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, resetn = 0, reqValid = 0, reqFetch = 0, reqSerBit = 0, reqMoreMem = 0;
  logic holdN = 1, slow = 0, irqCodeBit0 = 0, irqCodeBit1 = 0, irqCodeBit2 = 0, seenF, seenS;
  logic reqDone, serInBit, coreStall, phase3RefN, addrOe, dataOe, memCycleStrobeN, ready;
  logic writeStrobeN, readDirection, ctrlOe, serialIoStrobe, busGrant, fetchCycleFlag;
  logic serialIoIn, serSeen;
  logic [13:0] reqAddr = '0, addrOut;
  logic [7:0] reqWrData = '0, rdData, dataOut, dataIn, wrSeen;
  logic [2:0] irqCode;
  ebi_pkg::ebi_op_type reqOp = ebi_pkg::EBI_NONE;
  int n_errors = 0, samples_checked = 0, cyc = 0, i;
  ebi_bus_interface u_ebi_bus_interface (.*);
  ebi_mem_model u_ebi_mem_model (.*);
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (fetchCycleFlag === 1'b1) seenF = 1;
    if (coreStall === 1'b1) seenS = 1;
    if (cyc == 4000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until the done pulse
  task automatic op(input ebi_pkg::ebi_op_type o, input logic [13:0] a, input logic f, b);
    @(negedge sys_clk);
    reqOp = o;
    reqAddr = a;
    reqFetch = f;
    reqSerBit = b;
    reqValid = 1;
    seenF = 0;
    seenS = 0;
    for (i = 0; i < 80 && reqDone !== 1'b1; i++) @(negedge sys_clk);
    chk("done", 8'h1, reqDone);
    reqValid = 0;
  endtask
  task automatic t_mem;
    op(ebi_pkg::EBI_MEM_READ, 14'h0123, 1, 0);
    chk("rdData", 8'h79, rdData);
    chk("fetch", 8'h1, seenF);
    reqWrData = 8'hC3;
    op(ebi_pkg::EBI_MEM_WRITE, 14'h0040, 0, 0);
    chk("wrData", 8'hC3, wrSeen);
    chk("fetch", 8'h0, seenF);
    slow = 1;
    op(ebi_pkg::EBI_MEM_READ, 14'h00FF, 0, 0);
    chk("rdData", 8'hA5, rdData);
    chk("stall", 8'h1, seenS);
    slow = 0;
  endtask
  task automatic t_serial;
    for (int k = 0; k < 4; k++) begin
      op(k < 2 ? ebi_pkg::EBI_SER_OUT : ebi_pkg::EBI_EXT_INSTR, 14'h0000, 0, k[0]);
      chk("serOut", {7'h0, k[0]}, serSeen);
      op(ebi_pkg::EBI_SER_IN, k[0] ? 14'h0020 : 14'h0000, 0, 0);
      chk("serIn", {7'h0, k[0]}, serInBit);
    end
  endtask
  // Chained read: hold raised mid chain must wait for its end
  task automatic t_chain;
    reqMoreMem = 1;
    op(ebi_pkg::EBI_MEM_READ, 14'h0011, 0, 0);
    reqMoreMem = 0;
    holdN = 0;
    chk("chainStrobe", 8'h0, memCycleStrobeN);
    chk("chainGrant", 8'h0, busGrant);
    for (i = 0; i < 40 && busGrant !== 1'b1; i++) @(negedge sys_clk);
    chk("grant", 8'h1, busGrant);
    holdN = 1;
    for (i = 0; i < 40 && busGrant !== 1'b0; i++) @(negedge sys_clk);
    chk("grant", 8'h0, busGrant);
  endtask
  task automatic t_hold_irq;
    @(negedge sys_clk);
    {holdN, irqCodeBit2, irqCodeBit1, irqCodeBit0} = 4'h5;
    for (i = 0; i < 40 && busGrant !== 1'b1; i++) @(negedge sys_clk);
    chk("grant", 8'h1, busGrant);
    chk("irqCode", 8'h5, irqCode);
    holdN = 1;
    for (i = 0; i < 40 && busGrant !== 1'b0; i++) @(negedge sys_clk);
    chk("grant", 8'h0, busGrant);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    resetn = 1;
    t_mem();
    t_serial();
    t_chain();
    t_hold_irq();
    stop_test();
  end
endmodule
`default_nettype wire
